// ### core/jtag_debug_controller_core.sv
// test-port debug controller: virtual switches, input polling, memory access
// assumes a host command port on tck; memory engine and user memory on clk
`timescale 1ns/10ps
`include "jdc_params.svh"
module jtag_debug_controller_core (
  input logic clk,
  input logic rst_b,
  input logic tck,
  input logic cmd_valid,
  output logic cmd_ready,
  input jdc_pkg::op_t cmd_op,
  input logic [`MEM_AW-1:0] cmd_addr,
  input logic [`MEM_DW-1:0] cmd_data,
  input logic [`MEM_AW-1:0] cmd_count,
  input logic direct_mode,
  input logic [3:0] poll_rate,
  output logic rsp_valid,
  output logic [`MEM_DW-1:0] rsp_data,
  output logic [`SW_W-1:0] sw_out,
  input logic [`LED_W-1:0] led_in,
  output logic mem_clk,
  output logic mem_ce,
  output logic mem_wr_rdn,
  output logic [`MEM_AW-1:0] mem_addr,
  output logic [`MEM_DW-1:0] mem_wdata,
  input logic [`MEM_DW-1:0] mem_rdata
);
  import jdc_pkg::*;

  function automatic logic is_mem_op(input op_t op);
    is_mem_op = (op == `OP_MEM_INIT) || (op == `OP_MEM_READ) ||
      (op == `OP_MEM_WRITE) || (op == `OP_MEM_DUMP);
  endfunction

  // ---------------- test port clock domain ----------------
  logic rst_t1, rst_t2;
  logic [`LED_W-1:0] led_s1, led_s2;
  logic ack_s1, ack_s2, ack_s3, ack_edge;
  logic acc;
  t_state_e t_state;
  logic [`SW_W-1:0] sw_pend;
  logic [`POLL_W-1:0] poll_cnt;
  logic poll_fire;
  op_t m_op;
  logic [`MEM_AW-1:0] m_addr;
  logic [`MEM_DW-1:0] m_data;
  logic [`CNT_W-1:0] left;
  logic req_tgl;
  logic [`MEM_DW-1:0] rd_word;
  logic ack_tgl;

  // reset reaches the tck logic through two flops
  always_ff @(posedge tck) begin
    rst_t1 <= rst_b;
    rst_t2 <= rst_t1;
  end

  // user inputs are asynchronous to tck
  always_ff @(posedge tck) begin
    led_s1 <= led_in;
    led_s2 <= led_s1;
  end

  always_ff @(posedge tck) begin
    if (!rst_t2) begin
      ack_s1 <= 1'b0;
      ack_s2 <= 1'b0;
      ack_s3 <= 1'b0;
    end else begin
      ack_s1 <= ack_tgl;
      ack_s2 <= ack_s1;
      ack_s3 <= ack_s2;
    end
  end
  assign ack_edge = ack_s2 ^ ack_s3;

  // polling owns the port; only a stop gets through
  assign cmd_ready = (t_state == T_IDLE) ||
    ((t_state == T_POLL) && (cmd_op == `OP_LED_STOP));
  assign acc = cmd_valid && cmd_ready;

  always_ff @(posedge tck) begin
    if (!rst_t2) begin
      t_state <= T_IDLE;
    end else begin
      case (t_state)
        T_IDLE: begin
          if (acc && cmd_op == `OP_LED_START) begin
            t_state <= T_POLL;
          end else if (acc && is_mem_op(cmd_op)) begin
            t_state <= T_MEM;
          end
        end
        T_POLL: begin
          if (acc) begin
            t_state <= T_IDLE;
          end
        end
        T_MEM: begin
          if (ack_edge && left <= `CNT_W'(1)) begin
            t_state <= T_IDLE;
          end
        end
        default: t_state <= T_IDLE;
      endcase
    end
  end

  // switch outputs only move on an accepted command, so they hold otherwise
  always_ff @(posedge tck) begin
    if (!rst_t2) begin
      sw_pend <= '0;
      sw_out <= '0;
    end else if (acc) begin
      case (cmd_op)
        `OP_SW_WRITE: begin
          sw_pend <= cmd_data[`SW_W-1:0];
          if (direct_mode) begin
            sw_out <= cmd_data[`SW_W-1:0];
          end
        end
        `OP_SW_APPLY: sw_out <= sw_pend;
        `OP_SW_RESET: begin
          sw_pend <= '0;
          if (direct_mode) begin
            sw_out <= '0;
          end
        end
        default: ;
      endcase
    end
  end

  // first sample at once, then one every (POLL_BASE << poll_rate) + 1 tck cycles
  always_ff @(posedge tck) begin
    if (!rst_t2 || t_state != T_POLL) begin
      poll_cnt <= '0;
    end else if (poll_cnt == '0) begin
      poll_cnt <= `POLL_BASE << poll_rate;
    end else begin
      poll_cnt <= poll_cnt - `POLL_W'(1);
    end
  end
  assign poll_fire = (t_state == T_POLL) && (poll_cnt == '0) && !acc;

  // request fields stay still while the toggle is in flight to clk
  always_ff @(posedge tck) begin
    if (!rst_t2) begin
      m_op <= '0;
      m_addr <= '0;
      m_data <= '0;
      left <= '0;
      req_tgl <= 1'b0;
    end else if (t_state == T_IDLE && acc && is_mem_op(cmd_op)) begin
      m_op <= (cmd_op == `OP_MEM_DUMP) ? `OP_MEM_READ : cmd_op;
      m_addr <= cmd_addr;
      m_data <= cmd_data;
      if (cmd_op == `OP_MEM_DUMP) begin
        left <= (cmd_count == '0) ? `MEM_WORDS : {1'b0, cmd_count};
      end else begin
        left <= `CNT_W'(1);
      end
      req_tgl <= ~req_tgl;
    end else if (t_state == T_MEM && ack_edge && left > `CNT_W'(1)) begin
      m_addr <= m_addr + `MEM_AW'(1);
      left <= left - `CNT_W'(1);
      req_tgl <= ~req_tgl;
    end
  end

  always_ff @(posedge tck) begin
    if (!rst_t2) begin
      rsp_valid <= 1'b0;
      rsp_data <= '0;
    end else if (acc && cmd_op == `OP_LED_ONCE && t_state == T_IDLE) begin
      rsp_valid <= 1'b1;
      rsp_data <= `MEM_DW'(led_s2);
    end else if (poll_fire) begin
      rsp_valid <= 1'b1;
      rsp_data <= `MEM_DW'(led_s2);
    end else if (t_state == T_MEM && ack_edge && m_op == `OP_MEM_READ) begin
      rsp_valid <= 1'b1;
      rsp_data <= rd_word;
    end else begin
      rsp_valid <= 1'b0;
    end
  end

  // ---------------- user clock domain: memory engine ----------------
  logic req_s1, req_s2, req_s3, req_edge;
  m_state_e m_state;
  logic is_init;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      req_s1 <= 1'b0;
      req_s2 <= 1'b0;
      req_s3 <= 1'b0;
    end else begin
      req_s1 <= req_tgl;
      req_s2 <= req_s1;
      req_s3 <= req_s2;
    end
  end
  assign req_edge = req_s2 ^ req_s3;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      m_state <= M_IDLE;
    end else begin
      case (m_state)
        M_IDLE: if (req_edge) m_state <= M_SETUP;
        M_SETUP: m_state <= M_STROBE;
        M_STROBE: begin
          if (!mem_wr_rdn) begin
            m_state <= M_CAPT;
          end else if (is_init && mem_addr != `MEM_LAST) begin
            m_state <= M_SETUP;
          end else begin
            m_state <= M_DONE;
          end
        end
        M_CAPT: m_state <= M_DONE;
        M_DONE: m_state <= M_IDLE;
        default: m_state <= M_IDLE;
      endcase
    end
  end

  // memory clock is a strobe made from clk: high for one cycle per access
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      mem_clk <= 1'b0;
      mem_ce <= 1'b0;
      mem_wr_rdn <= 1'b0;
      mem_addr <= '0;
      mem_wdata <= '0;
      is_init <= 1'b0;
      rd_word <= '0;
      ack_tgl <= 1'b0;
    end else begin
      case (m_state)
        M_IDLE: begin
          if (req_edge) begin
            is_init <= (m_op == `OP_MEM_INIT);
            mem_addr <= (m_op == `OP_MEM_INIT) ? '0 : m_addr;
            mem_wdata <= m_data;
            mem_wr_rdn <= (m_op != `OP_MEM_READ);
            mem_ce <= 1'b1;
          end
        end
        M_SETUP: mem_clk <= 1'b1;
        M_STROBE: begin
          mem_clk <= 1'b0;
          if (mem_wr_rdn && is_init && mem_addr != `MEM_LAST) begin
            mem_addr <= mem_addr + `MEM_AW'(1);
          end
        end
        M_CAPT: rd_word <= mem_rdata;
        M_DONE: begin
          mem_ce <= 1'b0;
          mem_wr_rdn <= 1'b0;
          ack_tgl <= ~ack_tgl;
        end
        default: mem_clk <= 1'b0;
      endcase
    end
  end

  // ---------------- checks ----------------
  sequence s_wr_setup;
    m_state == M_SETUP && mem_wr_rdn;
  endsequence
  sequence s_rd_strobe;
    mem_clk && !mem_wr_rdn;
  endsequence

  a_direct_write: assert property (@(posedge tck) disable iff (!rst_t2)
    acc && cmd_op == `OP_SW_WRITE && direct_mode |=> sw_out == $past(cmd_data))
    else $error("direct switch write not applied");
  a_indirect_stage: assert property (@(posedge tck) disable iff (!rst_t2)
    acc && cmd_op == `OP_SW_WRITE && !direct_mode |=>
    $stable(sw_out) && sw_pend == $past(cmd_data))
    else $error("indirect switch write leaked");
  a_switch_apply: assert property (@(posedge tck) disable iff (!rst_t2)
    acc && cmd_op == `OP_SW_APPLY |=> sw_out == $past(sw_pend))
    else $error("apply did not update switches");
  a_switch_reset: assert property (@(posedge tck) disable iff (!rst_t2)
    acc && cmd_op == `OP_SW_RESET |=> sw_pend == '0)
    else $error("switch reset missed");
  a_switch_hold: assert property (@(posedge tck) disable iff (!rst_t2)
    !acc |=> $stable(sw_out))
    else $error("switches moved without command");
  a_poll_busy: assert property (@(posedge tck) disable iff (!rst_t2)
    t_state == T_POLL && cmd_op != `OP_LED_STOP |-> !cmd_ready ##1 t_state == T_POLL)
    else $error("port free during polling");
  a_poll_once: assert property (@(posedge tck) disable iff (!rst_t2)
    t_state == T_IDLE && acc && cmd_op == `OP_LED_ONCE |=>
    rsp_valid && rsp_data == $past(led_s2))
    else $error("single poll gave no sample");
  a_dump_step: assert property (@(posedge tck) disable iff (!rst_t2)
    t_state == T_MEM && ack_edge && left > `CNT_W'(1) |=>
    m_addr == $past(m_addr) + `MEM_AW'(1) && left == $past(left) - `CNT_W'(1))
    else $error("dump did not advance");
  a_write_strobe: assert property (@(posedge clk) disable iff (!rst_b)
    s_wr_setup |=> mem_clk && mem_ce && mem_wr_rdn ##1 !mem_clk)
    else $error("bad write strobe");
  a_read_capture: assert property (@(posedge clk) disable iff (!rst_b)
    s_rd_strobe |=> m_state == M_CAPT ##1 rd_word == $past(mem_rdata))
    else $error("read data not captured");
  a_init_sweep: assert property (@(posedge clk) disable iff (!rst_b)
    m_state == M_STROBE && is_init && mem_wr_rdn && mem_addr != `MEM_LAST |=>
    m_state == M_SETUP && mem_addr == $past(mem_addr) + `MEM_AW'(1))
    else $error("init sweep skipped");
endmodule

// ### core/jdc_params.svh
// constants for the test-port debug controller core
// assumes a host command port clocked by the test port clock
// Overview of operation
// - switch output and input sample vectors, each at most 32 bits wide.
// - switch outputs change on the test port clock, not the user clock.
// - direct mode writes each switch change to the outputs at once.
// - indirect mode stages switch edits; outputs change only on apply.
// - reset command returns every pending switch value to all zeros.
// - continuous polling samples inputs at a chosen rate and holds the port.
// - single polling samples the inputs once for each host request.
// - memory port drives clock, clock enable and write-high read-low select.
// - memory address bus is up to 16 bits wide.
// - memory write and read data buses are up to 32 bits wide.
// - initialise writes one default value to every memory address.
// - single read performs a read cycle and returns the captured word.
// - single write performs one write cycle at the given offset address.
// - dump reads consecutive addresses from a start for a count, else all.
`ifndef JDC_PARAMS_SVH
`define JDC_PARAMS_SVH
`define SW_W 32
`define LED_W 32
`define MEM_AW 16
`define MEM_DW 32
`define CNT_W 17
`define MEM_WORDS 17'h10000
`define MEM_LAST 16'hffff
`define POLL_W 24
`define POLL_BASE 24'h000010
`define OP_SW_WRITE 4'h1
`define OP_SW_APPLY 4'h2
`define OP_SW_RESET 4'h3
`define OP_LED_ONCE 4'h4
`define OP_LED_START 4'h5
`define OP_LED_STOP 4'h6
`define OP_MEM_INIT 4'h7
`define OP_MEM_READ 4'h8
`define OP_MEM_WRITE 4'h9
`define OP_MEM_DUMP 4'ha
`endif

// ### core/jdc_pkg.sv
// types shared by the debug controller core
// assumes jdc_params.svh supplies the widths
`include "jdc_params.svh"
package jdc_pkg;
  typedef logic [3:0] op_t;
  typedef enum {T_IDLE, T_POLL, T_MEM} t_state_e;
  typedef enum {M_IDLE, M_SETUP, M_STROBE, M_CAPT, M_DONE} m_state_e;
endpackage

// ### test/jdc_mem_model.sv
// user memory beside the core's access port: synchronous ram on mem_clk
// assumes ce, select, address and data settle before mem_clk rises
`timescale 1ns/10ps
module jdc_mem_model #(
  parameter logic [31:0] fill = 32'h0bad_0000
) (
  input logic mem_clk,
  input logic mem_ce,
  input logic mem_wr_rdn,
  input logic [15:0] mem_addr,
  input logic [31:0] mem_wdata,
  output logic [31:0] mem_rdata
);
  logic [31:0] mem [0:65535];
  // unwritten words read as fill
  initial begin
    mem_rdata = 32'h0000_0000;
    for (int i = 0; i < 65536; i++) mem[i] = fill;
  end
  // only the core reaches this port, so a single-port ram is safe here
  always @(posedge mem_clk) begin
    if (mem_ce && mem_wr_rdn) begin
      mem[mem_addr] <= mem_wdata;
      // scramble the output so stale read data is never taken for fresh
      mem_rdata <= ~mem_rdata;
    end else if (mem_ce) begin
      mem_rdata <= peek(mem_addr);
    end
  end
  function automatic logic [31:0] peek(input logic [15:0] a);
    return mem[a];
  endfunction
endmodule

// ### test/tb.sv
// bench for the debug controller core: switches, input polling, memory access
// assumes jdc_mem_model on the memory port; host commands driven on tck
`timescale 1ns/10ps
`include "jdc_params.svh"
module tb;
  import jdc_pkg::*;
  logic clk = 1'b0;
  logic tck = 1'b0;
  logic rst_b = 1'b0;
  logic cmd_valid = 1'b0;
  logic direct_mode = 1'b1;
  logic cmd_ready, rsp_valid, mem_clk, mem_ce, mem_wr_rdn;
  op_t cmd_op = 4'h0;
  logic [15:0] cmd_addr = 16'h0000;
  logic [15:0] cmd_count = 16'h0000;
  logic [15:0] mem_addr;
  logic [31:0] cmd_data = 32'h0000_0000;
  logic [31:0] led_in = 32'h0000_0000;
  logic [31:0] sw_s1, sw_s2;
  logic [31:0] rsp_data, sw_out, mem_wdata, mem_rdata;
  logic [3:0] poll_rate = 4'h0;
  logic [31:0] rq[$];
  logic [31:0] lv[2] = '{32'hc3c3_5a5a, 32'h0000_0001};
  logic [15:0] ma[4] = '{16'h0012, 16'h0013, 16'h0014, 16'hffff};
  logic [31:0] md[4] = '{32'h1111_0001, 32'h2222_0002, 32'h3333_0003, 32'hffff_fffe};
  int mismatches = 0;
  int checks = 0;
  int n;

  initial forever #2.5 clk = ~clk;
  // tck phase offset keeps the two domains unrelated
  initial begin
    #7;
    forever #32 tck = ~tck;
  end

  jtag_debug_controller_core jtag_debug_controller_core_inst (
    .clk(clk), .rst_b(rst_b), .tck(tck), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_data(cmd_data), .cmd_count(cmd_count),
    .direct_mode(direct_mode), .poll_rate(poll_rate), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .sw_out(sw_out), .led_in(led_in), .mem_clk(mem_clk),
    .mem_ce(mem_ce), .mem_wr_rdn(mem_wr_rdn), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));

  jdc_mem_model jdc_mem_model_inst (
    .mem_clk(mem_clk), .mem_ce(mem_ce), .mem_wr_rdn(mem_wr_rdn), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));

  // user side takes the switches through two flops on its own clock
  always @(posedge clk) begin
    sw_s1 <= sw_out;
    sw_s2 <= sw_s1;
  end

  // rsp_valid stands one tck, so the falling edge always sees it
  always @(negedge tck) if (rsp_valid === 1'b1) rq.push_back(rsp_data);

  task automatic results();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic idle();
    int i;
    @(negedge tck);
    for (i = 0; cmd_ready !== 1'b1; i++) begin
      if (i > 20000) begin
        mismatches++;
        results();
      end
      @(negedge tck);
    end
  endtask

  // one idle edge between requests; held until a rising edge that sees cmd_ready
  task automatic cmd(input op_t op, input logic [15:0] a, input logic [31:0] d,
                     input logic [15:0] c);
    int i;
    @(negedge tck);
    cmd_op = op;
    cmd_addr = a;
    cmd_data = d;
    cmd_count = c;
    cmd_valid = 1'b1;
    #1;
    for (i = 0; cmd_ready !== 1'b1; i++) begin
      if (i > 20000) begin
        mismatches++;
        results();
      end
      @(negedge tck);
      #1;
    end
    @(posedge tck);
    @(negedge tck);
    cmd_valid = 1'b0;
  endtask

  task automatic sw(input op_t op, input logic [31:0] d, input logic [31:0] exp);
    cmd(op, 16'h0000, d, 16'h0000);
    @(negedge tck);
    chk(sw_out, exp);
  endtask

  task automatic get(input logic [31:0] exp);
    int i;
    for (i = 0; rq.size() == 0; i++) begin
      if (i > 400) begin
        mismatches++;
        results();
      end
      @(negedge tck);
    end
    chk(rq.pop_front(), exp);
  endtask

  initial begin
    repeat (6) @(posedge tck);
    @(negedge clk);
    rst_b = 1'b1;
    repeat (4) @(negedge tck);
    chk(sw_out, 32'h0000_0000);
    sw(`OP_SW_WRITE, 32'ha5a5_0001, 32'ha5a5_0001);
    sw(`OP_SW_WRITE, 32'hffff_ffff, 32'hffff_ffff);
    sw(`OP_SW_RESET, 32'h0000_0000, 32'h0000_0000);
    direct_mode = 1'b0;
    sw(`OP_SW_WRITE, 32'h1234_5678, 32'h0000_0000);
    sw(`OP_SW_APPLY, 32'h0000_0000, 32'h1234_5678);
    repeat (8) @(negedge tck);
    chk(sw_out, 32'h1234_5678);
    chk(sw_s2, 32'h1234_5678);
    sw(`OP_SW_RESET, 32'h0000_0000, 32'h1234_5678);
    sw(`OP_SW_APPLY, 32'h0000_0000, 32'h0000_0000);
    $display("test switches done");
    foreach (lv[k]) begin
      led_in = lv[k];
      repeat (3) @(negedge tck);
      cmd(`OP_LED_ONCE, 16'h0000, 32'h0000_0000, 16'h0000);
      get(lv[k]);
    end
    for (int r = 0; r < 2; r++) begin
      poll_rate = r[3:0];
      rq.delete();
      cmd(`OP_LED_START, 16'h0000, 32'h0000_0000, 16'h0000);
      cmd_op = `OP_MEM_READ;
      @(negedge tck);
      chk(cmd_ready, 32'h0000_0000);
      repeat (39) @(negedge tck);
      n = rq.size();
      chk(n, 3 - r);
      foreach (rq[j]) chk(rq[j], 32'h0000_0001);
      cmd(`OP_LED_STOP, 16'h0000, 32'h0000_0000, 16'h0000);
    end
    rq.delete();
    $display("test polling done");
    foreach (ma[k]) cmd(`OP_MEM_WRITE, ma[k], md[k], 16'h0000);
    idle();
    foreach (ma[k]) chk(jdc_mem_model_inst.peek(ma[k]), md[k]);
    foreach (ma[k]) begin
      cmd(`OP_MEM_READ, ma[k], 32'h0000_0000, 16'h0000);
      get(md[k]);
    end
    cmd(`OP_MEM_DUMP, 16'h0012, 32'h0000_0000, 16'h0003);
    for (int k = 0; k < 3; k++) get(md[k]);
    $display("test memory done");
    cmd(`OP_MEM_INIT, 16'h0000, 32'h5a5a_0f0f, 16'h0000);
    idle();
    n = 0;
    for (int a = 0; a < 65536; a++) if (jdc_mem_model_inst.peek(a[15:0]) !== 32'h5a5a_0f0f) n++;
    chk(n, 0);
    cmd(`OP_MEM_READ, 16'hffff, 32'h0000_0000, 16'h0000);
    get(32'h5a5a_0f0f);
    $display("test init done");
    results();
  end
endmodule
